/* core/latched_io_pkg.sv */
// Constants shared by the latched I/O port group.
// Assumes a classic Wishbone master with 32-bit data and byte addresses.
package latched_io_pkg;

  localparam int DW = 32;
  localparam int AW = 8;
  localparam int PW = 4;

  // Port addresses 00h..1Fh; byte address is four times the port address
  localparam logic [4:0] PA_ANALOG_SEGMENT = 5'h04;
  localparam logic [4:0] PA_OUTPUT_ONLY = 5'h05;
  localparam logic [4:0] PA_SEGMENT = 5'h06;
  localparam logic [4:0] PA_OSC_PULSE = 5'h07;
  localparam logic [4:0] PA_IRQ_TIMER = 5'h08;
  localparam logic [4:0] PA_BIT_POINTER = 5'h1C;
  localparam logic [4:0] PA_BIT_OP = 5'h1D;
  localparam logic [4:0] PA_CONTROL = 5'h1E;

  // Reset values
  localparam logic [3:0] LATCH_RST = 4'hF;
  localparam logic [1:0] OUT_ONLY_RST = 2'h3;
  localparam logic [3:0] POINTER_RST = 4'h0;
  localparam logic [1:0] ANALOG_SEL_RST = 2'h0;

  // Bit-operation command codes, write data bits 1:0
  localparam logic [1:0] OP_SET = 2'h1;
  localparam logic [1:0] OP_CLEAR = 2'h2;
  localparam logic [1:0] OP_TEST = 2'h3;

  // Control register fields
  localparam int CTL_DUAL_CLOCK = 0;
  localparam int CTL_PULSE_EN = 1;
  localparam int CTL_ANALOG_LO = 4;
  localparam int CTL_ANALOG_HI = 5;

  // Bit-pointer codes that reach no pin
  localparam logic [3:0] PTR_NONE_A = 4'h6;
  localparam logic [3:0] PTR_NONE_B = 4'h7;

  // Instruction cycle: four clocks, states S1..S4 as phase 0..3
  localparam logic [1:0] SAMPLE_PHASE = 2'h2;
  localparam logic [1:0] DRIVE_PHASE = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CYC1 = 4'b0010,
    ST_CYC2 = 4'b0100,
    ST_ACK = 4'b1000
  } cyc_state_t;

endpackage

/* core/latched_io_port_group.sv */
// Latched I/O port group: five latched ports, indirect bit operations,
// shared-function pins, and external interrupt edge detection.
// Assumes a classic Wishbone master on CLK; pin inputs are synchronous.
`timescale 1ns/1ps

module latched_io_port_group (
  input wire logic CLK, // 40 MHz clock
  input wire logic NRST, // Asynchronous reset, active low
  input wire logic WB_CYC_I, // Wishbone cycle
  input wire logic WB_STB_I, // Wishbone strobe
  input wire logic WB_WE_I, // Wishbone write enable
  input wire logic [latched_io_pkg::AW-1:0] WB_ADR_I, // Byte address
  input wire logic [3:0] WB_SEL_I, // Byte selects
  input wire logic [latched_io_pkg::DW-1:0] WB_DAT_I, // Write data
  output logic [latched_io_pkg::DW-1:0] WB_DAT_O, // Read data
  output logic WB_ACK_O, // Wishbone acknowledge
  input wire logic [3:0] ANALOG_SEGMENT_PORT_I, // Pin levels
  output logic [3:0] ANALOG_SEGMENT_PORT_O, // Pin drive value
  output logic [3:0] ANALOG_SEGMENT_PORT_OE, // Pin drive enable
  output logic [1:0] ANALOG_SEL, // Active analog input
  output logic [1:0] OUTPUT_ONLY_PORT_O, // Output-only pins
  input wire logic [3:0] SEGMENT_PORT_I, // Pin levels
  output logic [3:0] SEGMENT_PORT_O, // Pin drive value
  output logic [3:0] SEGMENT_PORT_OE, // Pin drive enable
  input wire logic [3:0] OSCILLATOR_PULSE_PORT_I, // Pin levels
  output logic [3:0] OSCILLATOR_PULSE_PORT_O, // Pin drive value
  output logic [3:0] OSCILLATOR_PULSE_PORT_OE, // Pin drive enable
  input wire logic PULSE_IN, // Pulse generator signal
  input wire logic LOW_OSC_DRIVE, // Resonator amplifier output
  output logic LOW_OSC_IN, // Resonator input to oscillator
  output logic DUAL_CLOCK, // Dual-clock mode selected
  input wire logic [3:0] INTERRUPT_TIMER_PORT_I, // Pin levels
  output logic [3:0] INTERRUPT_TIMER_PORT_O, // Pin drive value
  output logic [3:0] INTERRUPT_TIMER_PORT_OE, // Pin drive enable
  output logic TIMER_INPUT, // Timer/counter input level
  output logic URGENT_EXTERNAL_IRQ, // Falling-edge pulse, urgent
  output logic MASKABLE_EXTERNAL_IRQ // Falling-edge pulse, maskable
);
  import latched_io_pkg::*;

  cyc_state_t state_r;
  cyc_state_t state_nxt;
  logic [1:0] phase_r;
  logic [4:0] port_addr;
  logic req;
  logic sample_now;
  logic drive_now;
  logic [3:0] as_lat_r;
  logic [1:0] oo_lat_r;
  logic [3:0] sg_lat_r;
  logic [3:0] op_lat_r;
  logic [3:0] it_lat_r;
  logic [3:0] ptr_r;
  logic dual_r;
  logic pulse_en_r;
  logic [1:0] analog_sel_r;
  logic test_r;
  logic [DW-1:0] rd_r;
  logic [DW-1:0] rd_nxt;
  logic [15:0] lat_vec;
  logic [15:0] lat_vec_nxt;
  logic [15:0] pin_vec;
  logic bit_op_wr;
  logic urg_prev_r;
  logic msk_prev_r;
  logic [3:0] op_drive;

  // Pointer value selects a pin unless it is one of the two gap codes
  function automatic logic ptr_valid(input logic [3:0] p);
    ptr_valid = (p != PTR_NONE_A) && (p != PTR_NONE_B);
  endfunction

  // Byte 0 must be enabled for a write to reach 4-bit data
  function automatic logic wr_hit(input logic [4:0] a, input logic [4:0] t,
                                  input logic we, input logic [3:0] sel);
    wr_hit = we && sel[0] && (a == t);
  endfunction

  assign port_addr = WB_ADR_I[6:2];
  assign req = WB_CYC_I && WB_STB_I && (WB_ADR_I[AW-1] == 1'b0);
  assign sample_now = (state_r == ST_CYC2) && (phase_r == SAMPLE_PHASE);
  assign drive_now = (state_r == ST_CYC2) && (phase_r == DRIVE_PHASE);

  // Two-instruction-cycle access sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (WB_CYC_I && WB_STB_I) begin
          state_nxt = ST_CYC1;
        end
      end
      ST_CYC1: begin
        if (phase_r == DRIVE_PHASE) begin
          state_nxt = ST_CYC2;
        end
      end
      ST_CYC2: begin
        if (phase_r == DRIVE_PHASE) begin
          state_nxt = ST_ACK;
        end
      end
      ST_ACK: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      phase_r <= 2'h0;
    end else if (state_r == ST_CYC1 || state_r == ST_CYC2) begin
      phase_r <= phase_r + 2'h1;
    end else begin
      phase_r <= 2'h0;
    end
  end

  assign WB_ACK_O = (state_r == ST_ACK);

  // Pointer-addressable view: 0-3, 4-5, 8-11, 12-15; 6 and 7 are holes
  assign lat_vec = {op_lat_r, sg_lat_r, 2'b00, oo_lat_r, as_lat_r};
  assign pin_vec = {OSCILLATOR_PULSE_PORT_I, SEGMENT_PORT_I, 2'b00,
                    oo_lat_r, ANALOG_SEGMENT_PORT_I};
  assign bit_op_wr = drive_now && req &&
                     wr_hit(port_addr, PA_BIT_OP, WB_WE_I, WB_SEL_I);

  always_comb begin
    lat_vec_nxt = lat_vec;
    if (bit_op_wr && ptr_valid(ptr_r)) begin
      if (WB_DAT_I[1:0] == OP_SET) begin
        lat_vec_nxt[ptr_r] = 1'b1;
      end else if (WB_DAT_I[1:0] == OP_CLEAR) begin
        lat_vec_nxt[ptr_r] = 1'b0;
      end
    end
  end

  // Port latches take new data only at S4 of the second cycle
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      as_lat_r <= LATCH_RST;
      oo_lat_r <= OUT_ONLY_RST;
      sg_lat_r <= LATCH_RST;
      op_lat_r <= LATCH_RST;
      it_lat_r <= LATCH_RST;
    end else if (drive_now && req) begin
      if (bit_op_wr) begin
        as_lat_r <= lat_vec_nxt[3:0];
        oo_lat_r <= lat_vec_nxt[5:4];
        sg_lat_r <= lat_vec_nxt[11:8];
        op_lat_r <= lat_vec_nxt[15:12];
      end
      if (wr_hit(port_addr, PA_ANALOG_SEGMENT, WB_WE_I, WB_SEL_I)) begin
        as_lat_r <= WB_DAT_I[3:0];
      end
      if (wr_hit(port_addr, PA_OUTPUT_ONLY, WB_WE_I, WB_SEL_I)) begin
        oo_lat_r <= WB_DAT_I[1:0];
      end
      if (wr_hit(port_addr, PA_SEGMENT, WB_WE_I, WB_SEL_I)) begin
        sg_lat_r <= WB_DAT_I[3:0];
      end
      if (wr_hit(port_addr, PA_OSC_PULSE, WB_WE_I, WB_SEL_I)) begin
        op_lat_r <= WB_DAT_I[3:0];
      end
      if (wr_hit(port_addr, PA_IRQ_TIMER, WB_WE_I, WB_SEL_I)) begin
        it_lat_r <= WB_DAT_I[3:0];
      end
    end
  end

  // Pointer and control also change at S4 so all writes look alike
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ptr_r <= POINTER_RST;
      dual_r <= 1'b0;
      pulse_en_r <= 1'b0;
      analog_sel_r <= ANALOG_SEL_RST;
    end else if (drive_now && req) begin
      if (wr_hit(port_addr, PA_BIT_POINTER, WB_WE_I, WB_SEL_I)) begin
        ptr_r <= WB_DAT_I[3:0];
      end
      if (wr_hit(port_addr, PA_CONTROL, WB_WE_I, WB_SEL_I)) begin
        dual_r <= WB_DAT_I[CTL_DUAL_CLOCK];
        pulse_en_r <= WB_DAT_I[CTL_PULSE_EN];
        analog_sel_r <= WB_DAT_I[CTL_ANALOG_HI:CTL_ANALOG_LO];
      end
    end
  end

  // Bit test samples the selected pin at S3; a hole reads as zero
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      test_r <= 1'b0;
    end else if (sample_now && req && WB_WE_I && WB_SEL_I[0] &&
                 port_addr == PA_BIT_OP && WB_DAT_I[1:0] == OP_TEST) begin
      test_r <= ptr_valid(ptr_r) ? pin_vec[ptr_r] : 1'b0;
    end
  end

  // Read mux; pins are unlatched, so the value is the S3 snapshot
  always_comb begin
    rd_nxt = '0;
    case (port_addr)
      PA_ANALOG_SEGMENT: rd_nxt[3:0] = ANALOG_SEGMENT_PORT_I;
      PA_OUTPUT_ONLY: rd_nxt[1:0] = oo_lat_r;
      PA_SEGMENT: rd_nxt[3:0] = SEGMENT_PORT_I;
      PA_OSC_PULSE: rd_nxt[3:0] = OSCILLATOR_PULSE_PORT_I;
      PA_IRQ_TIMER: rd_nxt[3:0] = INTERRUPT_TIMER_PORT_I;
      PA_BIT_POINTER: rd_nxt[3:0] = ptr_r;
      PA_BIT_OP: rd_nxt[0] = test_r;
      PA_CONTROL: begin
        rd_nxt[CTL_DUAL_CLOCK] = dual_r;
        rd_nxt[CTL_PULSE_EN] = pulse_en_r;
        rd_nxt[CTL_ANALOG_HI:CTL_ANALOG_LO] = analog_sel_r;
      end
      default: rd_nxt = '0;
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rd_r <= '0;
    end else if (sample_now && req && !WB_WE_I) begin
      rd_r <= rd_nxt;
    end
  end

  assign WB_DAT_O = rd_r;

  // Open-drain style pins: a zero latch pulls low, a one releases the pin; the output-only port drives its latch value directly
  assign ANALOG_SEGMENT_PORT_O = 4'h0;
  assign ANALOG_SEGMENT_PORT_OE = ~as_lat_r;
  assign ANALOG_SEL = analog_sel_r;
  assign OUTPUT_ONLY_PORT_O = oo_lat_r;
  assign SEGMENT_PORT_O = 4'h0;
  assign SEGMENT_PORT_OE = ~sg_lat_r;

  // Pulse output is gated by the latch; disable it before plain I/O use
  assign op_drive = {op_lat_r[3:2],
                     op_lat_r[1] & (pulse_en_r ? PULSE_IN : 1'b1),
                     op_lat_r[0]};

  always_comb begin
    OSCILLATOR_PULSE_PORT_O = 4'h0;
    OSCILLATOR_PULSE_PORT_OE = ~op_drive;
    if (dual_r) begin
      // Resonator owns bits 2 and 3; latch writes there have no effect
      OSCILLATOR_PULSE_PORT_OE[2] = 1'b0;
      OSCILLATOR_PULSE_PORT_O[3] = LOW_OSC_DRIVE;
      OSCILLATOR_PULSE_PORT_OE[3] = 1'b1;
    end
  end

  assign LOW_OSC_IN = dual_r & OSCILLATOR_PULSE_PORT_I[2];
  assign DUAL_CLOCK = dual_r;

  assign INTERRUPT_TIMER_PORT_O = 4'h0;
  assign INTERRUPT_TIMER_PORT_OE = ~it_lat_r;
  assign TIMER_INPUT = INTERRUPT_TIMER_PORT_I[3];

  // Edges are seen even when the pin serves as plain I/O
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      urg_prev_r <= 1'b1;
      msk_prev_r <= 1'b1;
    end else begin
      urg_prev_r <= INTERRUPT_TIMER_PORT_I[2];
      msk_prev_r <= INTERRUPT_TIMER_PORT_I[0];
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      URGENT_EXTERNAL_IRQ <= 1'b0;
      MASKABLE_EXTERNAL_IRQ <= 1'b0;
    end else begin
      URGENT_EXTERNAL_IRQ <= urg_prev_r & ~INTERRUPT_TIMER_PORT_I[2];
      MASKABLE_EXTERNAL_IRQ <= msk_prev_r & ~INTERRUPT_TIMER_PORT_I[0];
    end
  end

endmodule // latched_io_port_group

/* testbench/od_pins.sv */
// Open-drain pin model with pull-up for one 4-bit port.
// Assumes the bench raises pull to hold a pin low from outside.
`timescale 1ns/1ps
module od_pins (
  input wire logic [3:0] o, // Drive value
  input wire logic [3:0] oe, // Drive enable
  input wire logic [3:0] pull, // External pull low
  output logic [3:0] lvl // Pin level
);
  // Released pins float high; either party may pull low
  assign lvl = (~oe | o) & ~pull;
endmodule // od_pins

/* testbench/latched_io_props.sv */
// Checker for the latched I/O port group, bound to its top.
// Assumes one clock domain and registered acknowledge.
`timescale 1ns/1ps
module latched_io_props (
  input wire logic CLK, // Clock
  input wire logic NRST, // Reset
  input wire logic WB_CYC_I, // Cycle
  input wire logic WB_STB_I, // Strobe
  input wire logic WB_ACK_O, // Ack
  input wire logic [3:0] ANALOG_SEGMENT_PORT_OE, // Enables
  input wire logic [3:0] SEGMENT_PORT_OE, // Enables
  input wire logic [1:0] OUTPUT_ONLY_PORT_O, // Latch
  input wire logic [3:0] INTERRUPT_TIMER_PORT_I, // Levels
  input wire logic [3:0] OSCILLATOR_PULSE_PORT_I, // Levels
  input wire logic [3:0] OSCILLATOR_PULSE_PORT_O, // Drive
  input wire logic [3:0] OSCILLATOR_PULSE_PORT_OE, // Enables
  input wire logic LOW_OSC_DRIVE, // Resonator drive
  input wire logic LOW_OSC_IN, // Resonator input
  input wire logic DUAL_CLOCK, // Mode
  input wire logic TIMER_INPUT, // Timer level
  input wire logic URGENT_EXTERNAL_IRQ, // Pulse
  input wire logic MASKABLE_EXTERNAL_IRQ // Pulse
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  chk_ack_latency: assert property ($rose(WB_CYC_I && WB_STB_I)
    |=> !WB_ACK_O [*8] ##1 WB_ACK_O) else $error("ack not at cycle 9");
  chk_out_hold: assert property (!WB_ACK_O |-> $stable({
    ANALOG_SEGMENT_PORT_OE, SEGMENT_PORT_OE, OUTPUT_ONLY_PORT_O,
    DUAL_CLOCK})) else $error("outputs moved outside drive state");
  chk_urgent_edge: assert property ($fell(INTERRUPT_TIMER_PORT_I[2])
    |=> URGENT_EXTERNAL_IRQ ##1 !URGENT_EXTERNAL_IRQ)
    else $error("urgent irq pulse wrong");
  chk_mask_edge: assert property ($fell(INTERRUPT_TIMER_PORT_I[0])
    |=> MASKABLE_EXTERNAL_IRQ ##1 !MASKABLE_EXTERNAL_IRQ)
    else $error("maskable irq pulse wrong");
  chk_timer_level: assert property (
    TIMER_INPUT == INTERRUPT_TIMER_PORT_I[3]) else $error("timer input");
  chk_low_osc: assert property (LOW_OSC_IN ==
    (DUAL_CLOCK && OSCILLATOR_PULSE_PORT_I[2])) else $error("osc input");
  chk_dual_pins: assert property (DUAL_CLOCK |->
    OSCILLATOR_PULSE_PORT_OE[3] && !OSCILLATOR_PULSE_PORT_OE[2] &&
    OSCILLATOR_PULSE_PORT_O[3] == LOW_OSC_DRIVE) else $error("osc pins");
endmodule // latched_io_props

bind latched_io_port_group latched_io_props u_props (.*);

/* testbench/tb.sv */
// Self-checking bench for the latched I/O port group.
// Assumes open-drain pins with pull-ups modelled by od_pins.
`timescale 1ns/1ps
module tb;
  import latched_io_pkg::*;
  logic clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, pin = 0, lod = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0, pa_pu = 4'h0, sg_pu = 4'h0;
  logic [3:0] os_pu = 4'h0, it_pu = 4'h0;
  logic [31:0] wd = 32'h0000_0000, rd, dout;
  logic [3:0] pa_l, sg_l, os_l, it_l, pa_o, pa_oe, sg_o, sg_oe;
  logic [3:0] os_o, os_oe, it_o, it_oe;
  logic [1:0] asel, oo;
  logic ack, dual, uirq, mirq, losc, tmr;
  logic [15:0] vec;
  int error_cnt = 0, check_count = 0;
  always #12.5 clk = ~clk;
  latched_io_port_group dut (.CLK(clk), .NRST(nrst), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wd), .WB_DAT_O(dout), .WB_ACK_O(ack),
    .ANALOG_SEGMENT_PORT_I(pa_l), .ANALOG_SEGMENT_PORT_O(pa_o),
    .ANALOG_SEGMENT_PORT_OE(pa_oe), .ANALOG_SEL(asel),
    .OUTPUT_ONLY_PORT_O(oo), .SEGMENT_PORT_I(sg_l), .SEGMENT_PORT_O(sg_o),
    .SEGMENT_PORT_OE(sg_oe), .OSCILLATOR_PULSE_PORT_I(os_l),
    .OSCILLATOR_PULSE_PORT_O(os_o), .OSCILLATOR_PULSE_PORT_OE(os_oe),
    .PULSE_IN(pin), .LOW_OSC_DRIVE(lod), .LOW_OSC_IN(losc),
    .DUAL_CLOCK(dual), .INTERRUPT_TIMER_PORT_I(it_l),
    .INTERRUPT_TIMER_PORT_O(it_o), .INTERRUPT_TIMER_PORT_OE(it_oe),
    .TIMER_INPUT(tmr), .URGENT_EXTERNAL_IRQ(uirq),
    .MASKABLE_EXTERNAL_IRQ(mirq));
  od_pins u_pa (.o(pa_o), .oe(pa_oe), .pull(pa_pu), .lvl(pa_l));
  od_pins u_sg (.o(sg_o), .oe(sg_oe), .pull(sg_pu), .lvl(sg_l));
  od_pins u_os (.o(os_o), .oe(os_oe), .pull(os_pu), .lvl(os_l));
  od_pins u_it (.o(it_o), .oe(it_oe), .pull(it_pu), .lvl(it_l));
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task close_out;
    $display("mismatches %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Ack is looked at just after an edge so the next edge samples it
  task wb(input logic w, input logic [4:0] pa, input logic [31:0] d,
          input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {1'b0, pa, 2'b00};
    wd <= d;
    sel <= s;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (n >= 40) begin
      error_cnt++;
      close_out;
    end
    // Ack stands up to this edge: data is taken here, then released
    @(posedge clk);
    rd = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task wr(input logic [4:0] pa, input logic [31:0] d);
    wb(1'b1, pa, d, 4'hF);
  endtask
  task rdc(input logic [4:0] pa, input logic [31:0] e);
    wb(1'b0, pa, 32'h0000_0000, 4'hF);
    chk(rd, e);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    // No conversion runs here, so output accesses are always safe
    rdc(PA_ANALOG_SEGMENT, 32'h0000_000F);
    rdc(PA_OUTPUT_ONLY, 32'h0000_0003);
    chk(asel, ANALOG_SEL_RST);
    rdc(5'h10, 32'h0000_0000);
    wb(1'b1, PA_OUTPUT_ONLY, 32'h0000_0001, 4'hE);
    chk(oo, OUT_ONLY_RST);
    wr(PA_OUTPUT_ONLY, 32'h0000_0002);
    chk(oo, 2'h2);
    rdc(PA_OUTPUT_ONLY, 32'h0000_0002);
    wr(PA_ANALOG_SEGMENT, 32'h0000_0005);
    chk(pa_oe, 4'hA);
    pa_pu <= 4'h4;
    rdc(PA_ANALOG_SEGMENT, 32'h0000_0001);
    pa_pu <= 4'h0;
    wr(PA_ANALOG_SEGMENT, 32'h0000_000F);
    wr(PA_OUTPUT_ONLY, 32'h0000_0003);
    for (int p = 0; p < 16; p++) begin
      wr(PA_BIT_POINTER, p);
      wr(PA_BIT_OP, OP_CLEAR);
      vec = {os_oe, sg_oe, 2'b00, ~oo, pa_oe};
      chk(vec, (p == 6 || p == 7) ? 0 : 16'h1 << p);
      wr(PA_BIT_OP, OP_TEST);
      rdc(PA_BIT_OP, 32'h0000_0000);
      wr(PA_BIT_OP, OP_SET);
      wr(PA_BIT_OP, OP_TEST);
      rdc(PA_BIT_OP, (p == 6 || p == 7) ? 0 : 1);
    end
    wr(PA_CONTROL, 32'h0000_0033);
    chk(asel, 2'h3);
    chk(dual, 1'b1);
    chk(losc, 1'b1);
    chk(os_l[3], 1'b0);
    lod <= 1'b1;
    @(posedge clk);
    chk(os_l[3], 1'b1);
    chk(os_oe[1], 1'b1);
    pin <= 1'b1;
    @(posedge clk);
    chk(os_oe[1], 1'b0);
    wr(PA_CONTROL, 32'h0000_0000);
    // Only raw pulses here; the CPU keeps the mask bit at zero
    it_pu <= 4'h9;
    @(posedge clk);
    #1;
    chk(mirq, 1'b1);
    chk(uirq, 1'b0);
    chk(tmr, 1'b0);
    @(posedge clk);
    it_pu <= 4'hD;
    @(posedge clk);
    #1;
    chk(uirq, 1'b1);
    chk(mirq, 1'b0);
    @(posedge clk);
    it_pu <= 4'h0;
    wr(PA_IRQ_TIMER, 32'h0000_000B);
    chk(it_oe, 4'h4);
    wr(PA_OUTPUT_ONLY, 32'h0000_0000);
    chk(oo, 2'h0);
    wr(PA_CONTROL, 32'h0000_0020);
    chk(asel, 2'h2);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    chk({it_oe, 2'b00, oo}, 8'h03);
    chk(asel, ANALOG_SEL_RST);
    rdc(PA_OUTPUT_ONLY, 32'h0000_0003);
    close_out;
  end
  initial begin
    #500000;
    error_cnt++;
    close_out;
  end
endmodule // tb
